// *** hdl/edc_checker.sv ***
`timescale 1ns/1ps
module edc_checker
  import write_lock_pkg::*;
#(
  parameter int DATA_BITS = 64
)
(
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  // control
  input  wire logic                 enable,
  input  wire logic [DATA_BITS-1:0] image,
  // result
  output logic                      mismatch
);

  logic [7:0] code;
  logic [7:0] refCode;
  logic       refValid;

  function automatic logic [7:0] edc_calc(input logic [DATA_BITS-1:0] d);
    logic [7:0] c;
    c = EDC_SEED;
    for (int i = DATA_BITS - 1; i >= 0; i--)
    begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ EDC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : edc_calc

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      code <= 8'h00;
    else
      code <= edc_calc(image);
  end

  // reference taken on the first cycle after enabling, then compared every cycle
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refCode  <= 8'h00;
      refValid <= 1'b0;
      mismatch <= 1'b0;
    end
    else if (!enable)
    begin
      refValid <= 1'b0;
      mismatch <= 1'b0;
    end
    else if (!refValid)
    begin
      refCode  <= edc_calc(image);
      refValid <= 1'b1;
      mismatch <= 1'b0;
    end
    else
      mismatch <= (code != refCode);
  end

endmodule : edc_checker

// *** hdl/sync_two_ff.sv ***
`timescale 1ns/1ps
module sync_two_ff
  import write_lock_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // level crossing
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic stage1;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1  <= 1'b0;
      syncOut <= 1'b0;
    end
    else
    begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule : sync_two_ff

// *** hdl/write_lock_and_soft_reset.sv ***
// Notes on behaviour
// - lock blocks writes except the lock control register
// - lock bit stays set until device reset
// - locked: continuously check registers against reference code
// - locked: self-test disabled, start requests refused
// - locked: only reset code bits accept writes
// - bit 3 selects supply error reporting on SPI
// - SPI, bit 0: silent, then one error-code response
// - SPI, bit 0: clear on read/report, timer zero only
// - SPI, bit 1: silent while timer runs, self-clear
// - I2C: silent until expiry, status read clears
// - keys 00, 11, then bit1 set bit0 clear
// - write answer returns new value with reset code
// - third key resets; no answer, no acknowledge
// - read returns 00 code, aborts key sequence
// - reset code bits excluded from error code
// - one shared timer reloaded while supply fault present
`timescale 1ns/1ps
module write_lock_and_soft_reset
  import write_lock_pkg::*;
#(
  parameter int USER_REG_BITS   = 64,
  parameter int RECOVERY_CYCLES = SUPPLY_RECOVERY_CYCLES,
  parameter int TIMER_BITS      = 16
)
(
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  // register access from the serial front end
  input  wire logic                     accWrite,
  input  wire logic                     accRead,
  input  wire logic [7:0]               accAddr,
  input  wire logic [7:0]               accWdata,
  input  wire logic                     spiMode,
  // access answer
  output logic                          ansValid,
  output logic                          ansSilent,
  output logic [7:0]                    ansData,
  // write permission for other registers
  output logic                          writeAllowed,
  // data transmissions
  input  wire logic                     respSent,
  output logic                          respBlocked,
  output logic                          respErrorCode,
  // supply monitor
  input  wire logic                     supplyFaultPin,
  output logic                          supplyError,
  // register image check
  input  wire logic [USER_REG_BITS-1:0] userRegImage,
  input  wire logic                     rwErrorReported,
  output logic                          userRwError,
  // self-test
  input  wire logic                     selfTestReq,
  output logic                          selfTestStart,
  // control outputs
  output logic                          initDoneLock,
  output logic                          supplyErrorReportDisable,
  output logic                          softResetReq
);

  logic [7:0]            writeLockControl;
  logic [1:0]            resetCode;
  key_step_t             keyStep;
  key_step_t             next_keyStep;
  logic                  keyFires;
  logic                  ctrlWrite;
  logic                  ctrlRead;
  logic [7:0]            next_ctrl;
  logic                  supplyFault;
  logic [TIMER_BITS-1:0] supplyTimer;
  logic                  timerZero;
  logic                  timerExpire;
  logic                  errCodePending;
  logic                  supplyClear;
  logic                  edcMismatch;

  assign ctrlWrite = accWrite && (accAddr == ADDR_WRITE_LOCK_CONTROL);
  assign ctrlRead  = accRead && (accAddr == ADDR_WRITE_LOCK_CONTROL);

  assign initDoneLock             = writeLockControl[BIT_INIT_DONE_LOCK];
  assign supplyErrorReportDisable = writeLockControl[BIT_SUPPLY_REPORT_DIS];

  // other registers take writes only before the lock is set
  assign writeAllowed = !initDoneLock;

  // locked: only the reset code lands, lock bit can only be set
  always_comb
  begin
    next_ctrl = writeLockControl;
    if (initDoneLock)
      next_ctrl = (writeLockControl & ~MASK_RESET_CODE) | (accWdata & MASK_RESET_CODE);
    else
      next_ctrl = accWdata;
    next_ctrl[BIT_INIT_DONE_LOCK] = initDoneLock | accWdata[BIT_INIT_DONE_LOCK];
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      writeLockControl <= RESET_WRITE_LOCK;
    else if (ctrlWrite)
      writeLockControl <= next_ctrl;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      resetCode <= 2'b00;
    else if (ctrlWrite)
      resetCode <= accWdata[BIT_RESET_CODE_HI:BIT_RESET_CODE_LO];
    else if (ctrlRead)
      resetCode <= 2'b00;
  end

  // key tracker
  always_comb
  begin
    next_keyStep = keyStep;
    keyFires     = 1'b0;
    if (ctrlRead)
      next_keyStep = KEY_IDLE;
    else if (ctrlWrite)
    begin
      unique case (keyStep)
        KEY_IDLE:
          next_keyStep = (accWdata[1:0] == KEY_FIRST) ? KEY_GOT1 : KEY_IDLE;
        KEY_GOT1:
          next_keyStep = (accWdata[1:0] == KEY_SECOND) ? KEY_GOT2 :
                         (accWdata[1:0] == KEY_FIRST) ? KEY_GOT1 : KEY_IDLE;
        KEY_GOT2:
        begin
          keyFires     = (accWdata[1:0] == KEY_THIRD);
          next_keyStep = (accWdata[1:0] == KEY_FIRST) ? KEY_GOT1 : KEY_IDLE;
        end
        default:
          next_keyStep = KEY_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      keyStep <= KEY_IDLE;
    else
      keyStep <= next_keyStep;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      softResetReq <= 1'b0;
    else
      softResetReq <= keyFires;
  end

  // access answers, one cycle after the request
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ansValid  <= 1'b0;
      ansSilent <= 1'b0;
      ansData   <= 8'h00;
    end
    else
    begin
      ansValid  <= (accWrite || accRead) && !keyFires && !respBlocked;
      ansSilent <= (accWrite || accRead) && (keyFires || respBlocked);
      if (ctrlWrite)
        ansData <= next_ctrl;
      else if (ctrlRead)
        ansData <= writeLockControl & ~MASK_RESET_CODE;
      else if (accWrite || accRead)
        ansData <= 8'h00;
    end
  end

  // shared supply timer
  sync_two_ff u_supply_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .asyncIn (supplyFaultPin),
    .syncOut (supplyFault)
  );

  assign timerZero   = (supplyTimer == '0);
  assign timerExpire = (supplyTimer == TIMER_BITS'(1)) && !supplyFault;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      supplyTimer <= '0;
    else if (supplyFault)
      supplyTimer <= TIMER_BITS'(RECOVERY_CYCLES);
    else if (!timerZero)
      supplyTimer <= supplyTimer - TIMER_BITS'(1);
  end

  // supply error clearing per interface and report mode
  always_comb
  begin
    supplyClear = 1'b0;
    if (!spiMode)
      supplyClear = timerZero && accRead && (accAddr == ADDR_SUPPLY_STATUS);
    else if (supplyErrorReportDisable)
      supplyClear = timerZero;
    else
      supplyClear = timerZero && ((accRead && (accAddr == ADDR_SUPPLY_STATUS)) ||
                                  (respSent && errCodePending));
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      supplyError <= 1'b0;
    else if (supplyFault)
      supplyError <= 1'b1;
    else if (supplyClear)
      supplyError <= 1'b0;
  end

  // no response while the timer runs, in every mode
  assign respBlocked = !timerZero;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      errCodePending <= 1'b0;
    else if (timerExpire && spiMode && !supplyErrorReportDisable)
      errCodePending <= 1'b1;
    else if (respSent || !spiMode || supplyErrorReportDisable)
      errCodePending <= 1'b0;
  end

  assign respErrorCode = errCodePending && timerZero;

  // register image check while locked, reset code left out
  edc_checker #(
    .DATA_BITS (USER_REG_BITS + 6)
  ) u_edc (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .enable   (initDoneLock),
    .image    ({userRegImage, writeLockControl[7:2]}),
    .mismatch (edcMismatch)
  );

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      userRwError <= 1'b0;
    else if (edcMismatch)
      userRwError <= 1'b1;
    else if ((accRead && (accAddr == ADDR_DEVICE_STATUS)) || rwErrorReported)
      userRwError <= 1'b0;
  end

  // self-test gate
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      selfTestStart <= 1'b0;
    else
      selfTestStart <= selfTestReq && !initDoneLock;
  end

endmodule : write_lock_and_soft_reset

// *** hdl/write_lock_pkg.sv ***
package write_lock_pkg;

  // register map
  localparam logic [7:0] ADDR_WRITE_LOCK_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_SUPPLY_STATUS      = 8'h02;
  localparam logic [7:0] ADDR_DEVICE_STATUS      = 8'h03;
  localparam logic [7:0] RESET_WRITE_LOCK        = 8'h00;

  // field positions of write_lock_control
  localparam int BIT_INIT_DONE_LOCK     = 7;
  localparam int BIT_SUPPLY_REPORT_DIS  = 3;
  localparam int BIT_RESET_CODE_HI      = 1;
  localparam int BIT_RESET_CODE_LO      = 0;
  localparam logic [7:0] MASK_RESET_CODE = 8'h03;

  // soft reset key codes, written as {bit1, bit0}
  localparam logic [1:0] KEY_FIRST  = 2'b00;
  localparam logic [1:0] KEY_SECOND = 2'b11;
  localparam logic [1:0] KEY_THIRD  = 2'b10;

  typedef enum logic [1:0] {
    KEY_IDLE   = 2'b00,
    KEY_GOT1   = 2'b01,
    KEY_GOT2   = 2'b10
  } key_step_t;

  // timing
  localparam int CLK_HZ                  = 10_000_000;
  localparam int SUPPLY_RECOVERY_TIME_US = 100;
  localparam int SUPPLY_RECOVERY_CYCLES  =
    (SUPPLY_RECOVERY_TIME_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
    SUPPLY_RECOVERY_TIME_US * (CLK_HZ / 1_000_000);

  // error detection code
  localparam logic [7:0] EDC_POLY = 8'h2F;
  localparam logic [7:0] EDC_SEED = 8'hFF;

endpackage : write_lock_pkg

// *** test/host_model.sv ***
`timescale 1ns/1ps
module host_model
  import write_lock_pkg::*;
(
  // clock
  input  wire logic       clk_sys,
  // register access
  output logic            accWrite,
  output logic            accRead,
  output logic [7:0]      accAddr,
  output logic [7:0]      accWdata,
  // answer
  input  wire logic       ansSilent,
  input  wire logic [7:0] ansData
);
  initial
  begin
    accWrite = 1'b0;
    accRead  = 1'b0;
    accAddr  = 8'h00;
    accWdata = 8'h00;
  end
  // one access; released lines show the inverse so stale values are not trusted
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic s, output logic [7:0] q);
    @(posedge clk_sys);
    accWrite <= w;
    accRead  <= !w;
    accAddr  <= a;
    accWdata <= d;
    @(posedge clk_sys);
    accWrite <= 1'b0;
    accRead  <= 1'b0;
    accAddr  <= ~a;
    accWdata <= ~d;
    #1;
    s = ansSilent;
    q = ansData;
  endtask : xfer
  // soft reset key, three writes in order
  task automatic key(output logic s);
    logic [7:0] q;
    xfer(1'b1, ADDR_WRITE_LOCK_CONTROL, {6'h00, KEY_FIRST}, s, q);
    xfer(1'b1, ADDR_WRITE_LOCK_CONTROL, {6'h00, KEY_SECOND}, s, q);
    xfer(1'b1, ADDR_WRITE_LOCK_CONTROL, {6'h00, KEY_THIRD}, s, q);
  endtask : key
endmodule : host_model

// *** test/write_lock_and_soft_reset_assertions.sv ***
`timescale 1ns/1ps
module write_lock_checker
  import write_lock_pkg::*;
#(
  parameter int RECOVERY_CYCLES = SUPPLY_RECOVERY_CYCLES
)
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_n,
  // access
  input wire logic       accWrite,
  input wire logic       accRead,
  input wire logic [7:0] accAddr,
  input wire logic [7:0] accWdata,
  input wire logic       spiMode,
  // answer and status
  input wire logic       ansValid,
  input wire logic       ansSilent,
  input wire logic [7:0] ansData,
  input wire logic       writeAllowed,
  input wire logic       respBlocked,
  input wire logic       respErrorCode,
  input wire logic       supplyFaultPin,
  input wire logic       selfTestStart,
  input wire logic       initDoneLock,
  input wire logic       supplyErrorReportDisable,
  input wire logic       softResetReq,
  input wire logic       userRwError
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  int lowCnt;
  wire logic lockWr = accWrite && accAddr == ADDR_WRITE_LOCK_CONTROL;
  // cycles since the supply monitor last flagged a fault
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      lowCnt <= 0;
    else if (supplyFaultPin)
      lowCnt <= 0;
    else if (lowCnt < 1000)
      lowCnt <= lowCnt + 1;
  AST_WRITE_GATE: assert property (writeAllowed == !initDoneLock)
    else $error("write permission does not follow the lock");
  AST_LOCK_HOLD: assert property (initDoneLock |=> initDoneLock)
    else $error("lock bit cleared");
  AST_SELFTEST_OFF: assert property (initDoneLock |=> !selfTestStart)
    else $error("self-test started while locked");
  AST_LOCKED_CTRL: assert property (initDoneLock && lockWr |=> $stable(supplyErrorReportDisable))
    else $error("locked write changed a control bit");
  AST_KEY_FIRE: assert property (softResetReq |-> ansSilent && $past(lockWr)
    && (8'h03 & $past(accWdata)) == {6'h00, KEY_THIRD})
    else $error("soft reset without third key");
  AST_ECHO: assert property (lockWr && !initDoneLock && !respBlocked
    |=> ansSilent || ansData == $past(accWdata))
    else $error("write answer differs from written value");
  AST_READ_ZERO: assert property (accRead && accAddr == ADDR_WRITE_LOCK_CONTROL
    |=> (ansData & MASK_RESET_CODE) == 8'h00)
    else $error("read shows reset code");
  AST_SILENT: assert property ((accRead || accWrite) && respBlocked |=> ansSilent && !ansValid)
    else $error("answer given while blocked");
  AST_ERRCODE: assert property ($fell(respBlocked) && spiMode && !supplyErrorReportDisable
    |-> ##[0:1] respErrorCode)
    else $error("no error code after expiry");
  AST_FAULT_BLOCK: assert property ($rose(supplyFaultPin) |-> ##[1:5] respBlocked)
    else $error("fault did not block responses");
  AST_RECOVERY: assert property (lowCnt > RECOVERY_CYCLES + 4 |-> !respBlocked)
    else $error("responses blocked past recovery time");
  COV_RESET: cover property (softResetReq);
  COV_ERRCODE: cover property (respErrorCode);
  COV_RWERR: cover property (userRwError);
endmodule : write_lock_checker
bind write_lock_and_soft_reset write_lock_checker #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) chk (
  .clk_sys, .rst_n, .accWrite, .accRead, .accAddr, .accWdata, .spiMode, .ansValid,
  .ansSilent, .ansData, .writeAllowed, .respBlocked, .respErrorCode, .supplyFaultPin,
  .selfTestStart, .initDoneLock, .supplyErrorReportDisable, .softResetReq, .userRwError);

// *** test/write_lock_and_soft_reset_bench.sv ***
`timescale 1ns/1ps
module write_lock_and_soft_reset_bench;
  import write_lock_pkg::*;
  localparam logic [7:0] A = ADDR_WRITE_LOCK_CONTROL;
  logic        clk_sys = 1'b0, rst_n = 1'b0, spiMode = 1'b1, respSent = 1'b0;
  logic        supplyFaultPin = 1'b0, rwErrorReported = 1'b0, selfTestReq = 1'b0;
  logic [63:0] userRegImage = 64'h0;
  logic        accWrite, accRead, ansValid, ansSilent, writeAllowed, respBlocked;
  logic        respErrorCode, supplyError, userRwError, selfTestStart, initDoneLock;
  logic        supplyErrorReportDisable, softResetReq, s;
  logic [7:0]  accAddr, accWdata, ansData, q;
  int          bad_count = 0, checks = 0, cycles = 0;
  always #50 clk_sys = ~clk_sys;
  host_model host (.clk_sys, .accWrite, .accRead, .accAddr, .accWdata, .ansSilent, .ansData);
  write_lock_and_soft_reset #(.RECOVERY_CYCLES(5)) uut (.clk_sys, .rst_n, .accWrite,
    .accRead, .accAddr, .accWdata, .spiMode, .ansValid, .ansSilent, .ansData, .writeAllowed,
    .respSent, .respBlocked, .respErrorCode, .supplyFaultPin, .supplyError, .userRegImage,
    .rwErrorReported, .userRwError, .selfTestReq, .selfTestStart, .initDoneLock,
    .supplyErrorReportDisable, .softResetReq);
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic do_reset;
    rst_n        <= 1'b0;
    userRegImage <= 64'h0;
    spiMode      <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask : do_reset
  // one-cycle pulse: 0 on the self-test request, otherwise on the response-sent strobe
  task automatic pulse(input int sel);
    @(posedge clk_sys);
    if (sel == 0)
      selfTestReq <= 1'b1;
    else
      respSent <= 1'b1;
    @(posedge clk_sys);
    selfTestReq <= 1'b0;
    respSent    <= 1'b0;
    #1;
  endtask : pulse
  // supply monitor flags a fault for three cycles, then waits for recovery
  task automatic fault_recover(input logic wr);
    @(posedge clk_sys);
    supplyFaultPin <= 1'b1;
    repeat (3) @(posedge clk_sys);
    supplyFaultPin <= 1'b0;
    host.xfer(1'b0, A, 8'h00, s, q);
    chk({7'h00, s}, 8'h01);
    chk({7'h00, respBlocked}, 8'h01);
    for (int i = 0; i < 40 && respBlocked; i++)
    begin
      @(posedge clk_sys);
      #1;
    end
  endtask : fault_recover
  task automatic t_plain;
    host.xfer(1'b0, A, 8'h00, s, q);
    chk(q, RESET_WRITE_LOCK);
    chk({6'h00, ansValid, s}, 8'h02);
    host.xfer(1'b1, A, 8'h0B, s, q);
    chk(q, 8'h0B);
    chk({7'h00, supplyErrorReportDisable}, 8'h01);
    host.xfer(1'b0, A, 8'h00, s, q);
    chk(q, 8'h08);
    pulse(0);
    chk({7'h00, selfTestStart}, 8'h01);
  endtask : t_plain
  task automatic t_key;
    host.xfer(1'b1, A, 8'h00, s, q);
    host.xfer(1'b1, A, 8'h03, s, q);
    host.xfer(1'b0, A, 8'h00, s, q);
    host.xfer(1'b1, A, 8'h02, s, q);
    chk({6'h00, s, softResetReq}, 8'h00);
    host.xfer(1'b1, A, 8'h00, s, q);
    host.xfer(1'b1, A, 8'h02, s, q);
    chk({6'h00, s, softResetReq}, 8'h00);
    host.key(s);
    chk({6'h00, s, softResetReq}, 8'h03);
  endtask : t_key
  task automatic t_lock;
    host.xfer(1'b1, A, 8'h80, s, q);
    chk({7'h00, writeAllowed}, 8'h00);
    host.xfer(1'b1, A, 8'h0B, s, q);
    chk(q, 8'h83);
    host.xfer(1'b1, A, 8'h00, s, q);
    chk(q, 8'h80);
    pulse(0);
    chk({7'h00, selfTestStart}, 8'h00);
    repeat (4) @(posedge clk_sys);
    #1;
    chk({7'h00, userRwError}, 8'h00);
    @(posedge clk_sys);
    userRegImage <= 64'h0000_0000_0000_0001;
    repeat (4) @(posedge clk_sys);
    #1;
    chk({7'h00, userRwError}, 8'h01);
  endtask : t_lock
  task automatic t_supply;
    fault_recover(1'b0);
    chk({6'h00, respErrorCode, supplyError}, 8'h03);
    pulse(1);
    chk({6'h00, respErrorCode, supplyError}, 8'h00);
    @(posedge clk_sys);
    spiMode <= 1'b0;
    fault_recover(1'b0);
    chk({6'h00, respErrorCode, supplyError}, 8'h01);
    host.xfer(1'b0, ADDR_SUPPLY_STATUS, 8'h00, s, q);
    @(posedge clk_sys);
    #1;
    chk({7'h00, supplyError}, 8'h00);
    @(posedge clk_sys);
    spiMode <= 1'b1;
    host.xfer(1'b1, A, 8'h08, s, q);
    fault_recover(1'b0);
    @(posedge clk_sys);
    #1;
    chk({6'h00, respErrorCode, supplyError}, 8'h00);
  endtask : t_supply
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      finish_test;
    end
  end
  initial
  begin
    do_reset;
    t_plain;
    t_key;
    do_reset;
    t_lock;
    do_reset;
    t_supply;
    finish_test;
  end
endmodule : write_lock_and_soft_reset_bench
